// ---- logic/ssu_top.sv ----
// Purpose: six-channel serial unit with pin routing, boot mode and reset output
// Assumes: pin_in and boot_select_pins are asynchronous; other inputs are on mclk
// Notes: pin index 0..31 covers ports B, C, D, E; a tx or rx sel of 3 leaves a signal unrouted
`timescale 1ns/1ps
module ssu_top #(
   parameter int RST_CYC = ssu_pkg::RST_OUT_CYC
) (
   input wire logic mclk,
   input wire logic arst_n,
   input wire logic clk_en,
   input wire logic boot_select_pins,
   input wire logic prog_status,
   input wire logic download_done,
   input wire logic status_gpo,
   output logic status_out,
   output logic boot_level,
   output logic prog_mode,
   output logic reset_out_n,
   input ssu_pkg::ssu_mode_t cfg_mode [ssu_pkg::NCH],
   input wire logic [ssu_pkg::NCH-1:0][15:0] cfg_div,
   input wire logic [ssu_pkg::NCH-1:0] cfg_seven,
   input wire logic [ssu_pkg::NCH-1:0] cfg_ninth,
   input wire logic [ssu_pkg::NCH-1:0] cfg_master,
   input wire logic [ssu_pkg::NCH-1:0] cfg_irda,
   input wire logic [ssu_pkg::NCH-1:0][1:0] cfg_tx_sel,
   input wire logic [ssu_pkg::NCH-1:0][1:0] cfg_rx_sel,
   input wire logic [ssu_pkg::NCH-1:0][2:0] cfg_clk_sel,
   input wire logic [ssu_pkg::NCH-1:0] tx_valid,
   input wire logic [ssu_pkg::NCH-1:0][8:0] tx_data,
   output logic [ssu_pkg::NCH-1:0] tx_take,
   output logic [ssu_pkg::NCH-1:0] rx_valid,
   output logic [ssu_pkg::NCH-1:0][8:0] rx_data,
   output logic [ssu_pkg::NCH-1:0] rx_err,
   input wire logic [ssu_pkg::NPIN-1:0] pin_in,
   output logic [ssu_pkg::NPIN-1:0] pin_out,
   output logic [ssu_pkg::NPIN-1:0] pin_oe_n
);
   import ssu_pkg::*;

   if (RST_CYC < 1 || RST_CYC > 65535) begin : g_chk
      $error("reset stretch must be 1 to 65535 cycles");
   end

   logic [NPIN-1:0] ps1_q, ps2_q, pout_d, pdrv_d;
   logic bs1_q, bs2_q, boot_done_q, dl_q;
   logic [1:0] cap_q;
   logic [15:0] rcnt_q;
   logic [NCH-1:0] ch_on, tvalid_g, tx_line, sclk_o, sclk_d, rx_line, sclk_i;
   logic [5:0] tx_pin [NCH];
   logic [5:0] rx_pin [NCH];
   logic [5:0] ck_pin [NCH];
   ssu_mode_t cmode [NCH];
   logic [NCH-1:0][15:0] cdiv;
   logic [NCH-1:0][1:0] txs, rxs;

   // two-stage synchronisers for everything arriving from pins
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         ps1_q <= '1;
         ps2_q <= '1;
         bs1_q <= 1'b0;
         bs2_q <= 1'b0;
      end else if (clk_en) begin
         ps1_q <= pin_in;
         ps2_q <= ps1_q;
         bs1_q <= boot_select_pins;
         bs2_q <= bs1_q;
      end
   end

   // boot level is caught only once the synchroniser holds the real pin value
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         cap_q <= '0;
         boot_done_q <= 1'b0;
         prog_mode <= 1'b0;
         boot_level <= 1'b0;
      end else if (clk_en) begin
         boot_level <= bs2_q;
         if (cap_q != 2'h2) begin
            cap_q <= cap_q + 2'h1;
         end else if (!boot_done_q) begin
            boot_done_q <= 1'b1;
            prog_mode <= bs2_q;
         end
      end
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         dl_q <= 1'b0;
         status_out <= 1'b0;
      end else if (clk_en) begin
         dl_q <= dl_q || download_done;
         status_out <= (prog_mode && !dl_q) ? prog_status : status_gpo;
      end
   end

   // reset output held low for the stretch after the reset input lets go
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         rcnt_q <= 16'(RST_CYC);
         reset_out_n <= 1'b0;
      end else if (clk_en) begin
         if (rcnt_q != 16'h0000) begin
            rcnt_q <= rcnt_q - 16'h0001;
         end
         reset_out_n <= (rcnt_q == 16'h0000);
      end
   end

   always_comb begin
      for (int c = 0; c < NCH; c++) begin
         cmode[c] = cfg_mode[c];
         cdiv[c] = cfg_div[c];
         txs[c] = cfg_tx_sel[c];
         rxs[c] = cfg_rx_sel[c];
         ch_on[c] = (c < 4) || (txs[c] != SEL_NONE && rxs[c] != SEL_NONE);
      end
      // program mode hands channel A to the loader as a fixed async port
      if (prog_mode) begin
         cmode[0] = SSU_ASYNC;
         cdiv[0] = BOOT_DIV;
         txs[0] = BOOT_TX_SEL;
         rxs[0] = BOOT_RX_SEL;
      end
      for (int c = 0; c < NCH; c++) begin
         tx_pin[c] = (txs[c] == SEL_NONE) ? NOPIN : TX_PIN[c][txs[c]];
         rx_pin[c] = (rxs[c] == SEL_NONE) ? NOPIN : RX_PIN[c][rxs[c]];
         if (c >= 4) begin
            ck_pin[c] = (txs[c] == SEL_NONE) ? NOPIN : CK_PIN[c][txs[c]];
         end else begin
            ck_pin[c] = (cfg_clk_sel[c] >= 3'(CK_SELS)) ? NOPIN : CK_PIN[c][cfg_clk_sel[c]];
         end
         tvalid_g[c] = tx_valid[c] && ch_on[c];
         rx_line[c] = (rx_pin[c] == NOPIN) ? 1'b1 : ps2_q[rx_pin[c][4:0]];
         sclk_i[c] = (ck_pin[c] == NOPIN) ? 1'b1 : ps2_q[ck_pin[c][4:0]];
      end
   end

   // later channels win a pin shared by two choices; software avoids such clashes
   always_comb begin
      pout_d = '1;
      pdrv_d = '0;
      for (int c = 0; c < NCH; c++) begin
         if (ch_on[c] && tx_pin[c] != NOPIN) begin
            pout_d[tx_pin[c][4:0]] = tx_line[c];
            pdrv_d[tx_pin[c][4:0]] = 1'b1;
         end
         if (ch_on[c] && sclk_d[c] && ck_pin[c] != NOPIN) begin
            pout_d[ck_pin[c][4:0]] = sclk_o[c];
            pdrv_d[ck_pin[c][4:0]] = 1'b1;
         end
      end
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         pin_out <= '1;
         pin_oe_n <= '1;
      end else if (clk_en) begin
         pin_out <= pout_d;
         pin_oe_n <= ~pdrv_d;
      end
   end

   for (genvar c = 0; c < NCH; c++) begin : g_ch
      ssu_chan #(
         .HAS_SYNC(c < 4),
         .HAS_HDLC(c >= 4)
      ) u_chan (
         .mclk(mclk),
         .arst_n(arst_n),
         .clk_en(clk_en),
         .div(cdiv[c]),
         .seven(cfg_seven[c]),
         .ninth(cfg_ninth[c]),
         .mode(cmode[c]),
         .master(cfg_master[c]),
         .irda(cfg_irda[c]),
         .tx_valid(tvalid_g[c]),
         .tx_data(tx_data[c]),
         .tx_take(tx_take[c]),
         .tx_line(tx_line[c]),
         .rx_line(rx_line[c]),
         .sclk_in(sclk_i[c]),
         .sclk_out(sclk_o[c]),
         .sclk_drv(sclk_d[c]),
         .rx_valid(rx_valid[c]),
         .rx_data(rx_data[c]),
         .rx_err(rx_err[c])
      );
   end

   default clocking @(posedge mclk); endclocking
   default disable iff (!arst_n);
   a_boot_capture: assert property (clk_en && cap_q == 2'h2 && !boot_done_q
      |=> prog_mode == $past(bs2_q) && boot_done_q)
      else $error("boot mode not taken from boot-select level");
   a_boot_hold: assert property (boot_done_q |=> $stable(prog_mode))
      else $error("boot mode changed after capture");
   a_status_free: assert property (clk_en && (!prog_mode || dl_q)
      |=> status_out == $past(status_gpo))
      else $error("status line not released to general output");
   a_reset_out: assert property (rcnt_q != 16'h0000 |=> !reset_out_n)
      else $error("reset output released early");
   a_boot_port: assert property (prog_mode && clk_en && tx_pin[0] == 6'h0E
      |=> !pin_oe_n[14] && pin_out[14] == $past(tx_line[0]))
      else $error("boot port transmit not on its pin");
   a_unconf_idle: assert property (!$past(ch_on[4]) |-> !tx_take[4])
      else $error("unassigned channel took data");
   a_clk_port: assert property (ck_pin[5] != NOPIN |-> ck_pin[5][4:3] == tx_pin[5][4:3])
      else $error("framed channel clock off its data port");
   a_sync_drive: assert property (clk_en && sclk_d[1] && cmode[1] == SSU_SYNC
      |=> !pin_oe_n[0])
      else $error("master clock not driven on its pin");
   c_boot_prog: cover property (boot_done_q && prog_mode);
   c_a_sent: cover property (tx_take[0] ##[1:200] rx_valid[0]);
   c_b_sync: cover property (cmode[1] == SSU_SYNC && rx_valid[1]);
   c_e_frame: cover property (cmode[4] == SSU_HDLC && tx_take[4]);
endmodule // ssu_top

// ---- logic/ssu_pkg.sv ----
// Purpose: shared constants, modes and pin maps of the six-channel serial unit
// Assumes: pins indexed B0..B7=0..7, C0..C7=8..15, D0..D7=16..23, E0..E7=24..31
// Notes: NOPIN marks an empty routing choice
package ssu_pkg;
   localparam int NCH = 6;
   localparam int NPIN = 32;
   localparam int CK_SELS = 5;
   localparam int CLK_NS = 8;
   localparam int RST_OUT_NS = 1000;
   localparam int RST_OUT_CYC = (RST_OUT_NS + CLK_NS - 1) / CLK_NS;
   localparam logic [15:0] MIN_DIV = 16'h0008;
   localparam logic [15:0] BOOT_DIV = 16'h0010;
   localparam logic [1:0] SEL_NONE = 2'h3;
   localparam logic [1:0] BOOT_TX_SEL = 2'h0;
   localparam logic [1:0] BOOT_RX_SEL = 2'h0;
   localparam logic [5:0] NOPIN = 6'h3F;
   localparam logic [7:0] HDLC_FLAG = 8'h7E;
   localparam logic [2:0] STUFF_ONES = 3'h5;
   localparam logic [15:0] IRDA_NUM = 16'h0003;
   localparam int IRDA_SHIFT = 4;
   typedef enum logic [1:0] {SSU_ASYNC, SSU_SYNC, SSU_HDLC} ssu_mode_t;
   localparam logic [5:0] TX_PIN [NCH][3] = '{
      '{6'h0E, 6'h0F, 6'h3F}, '{6'h0C, 6'h0D, 6'h3F}, '{6'h0A, 6'h0B, 6'h3F},
      '{6'h08, 6'h09, 6'h3F}, '{6'h1E, 6'h0E, 6'h3F}, '{6'h12, 6'h1A, 6'h0A}};
   localparam logic [5:0] RX_PIN [NCH][3] = '{
      '{6'h0F, 6'h1F, 6'h3F}, '{6'h0D, 6'h1D, 6'h3F}, '{6'h0B, 6'h13, 6'h1B},
      '{6'h09, 6'h11, 6'h19}, '{6'h1F, 6'h0F, 6'h3F}, '{6'h13, 6'h1B, 6'h0B}};
   // A-D: sync clock choices; E,F: transmit clock, indexed by the data choice
   localparam logic [5:0] CK_PIN [NCH][CK_SELS] = '{
      '{6'h01, 6'h3F, 6'h3F, 6'h3F, 6'h3F}, '{6'h00, 6'h3F, 6'h3F, 6'h3F, 6'h3F},
      '{6'h12, 6'h1A, 6'h1F, 6'h0F, 6'h3F}, '{6'h10, 6'h13, 6'h18, 6'h1B, 6'h0B},
      '{6'h1C, 6'h0C, 6'h3F, 6'h3F, 6'h3F}, '{6'h10, 6'h18, 6'h08, 6'h3F, 6'h3F}};
endpackage

// ---- logic/ssu_chan.sv ----
// Purpose: one serial channel: async, clocked and bit-stuffed framed transmit
// Assumes: rx_line and sclk_in already synchronised to mclk
// Notes: framed mode is transmit only; its receive path stays idle
`timescale 1ns/1ps
module ssu_chan #(
   parameter bit HAS_SYNC = 1'b0,
   parameter bit HAS_HDLC = 1'b0
) (
   input wire logic mclk,
   input wire logic arst_n,
   input wire logic clk_en,
   input wire logic [15:0] div,
   input wire logic seven,
   input wire logic ninth,
   input ssu_pkg::ssu_mode_t mode,
   input wire logic master,
   input wire logic irda,
   input wire logic tx_valid,
   input wire logic [8:0] tx_data,
   output logic tx_take,
   output logic tx_line,
   input wire logic rx_line,
   input wire logic sclk_in,
   output logic sclk_out,
   output logic sclk_drv,
   output logic rx_valid,
   output logic [8:0] rx_data,
   output logic rx_err
);
   import ssu_pkg::*;
   typedef enum logic [1:0] {H_IDLE, H_OPEN, H_DATA, H_CLOSE} ssu_hst_t;
   ssu_hst_t hst_q;
   logic sync_m, hdlc_m, tick, rise, fall, tx_ev, stuff, run, sck_q, sin_q, line_q, rbusy_q;
   logic [15:0] dv, half, reload, tcnt_q, rcnt_q, pw;
   logic [10:0] fr, tsr_q;
   logic [3:0] nb, nb_q, rbit_q, rlast;
   logic [2:0] ones_q;
   logic [8:0] rsr_q;

   assign dv = (div < MIN_DIV) ? MIN_DIV : div;
   assign half = {1'b0, dv[15:1]};
   assign sync_m = HAS_SYNC && (mode == SSU_SYNC);
   assign hdlc_m = HAS_HDLC && (mode == SSU_HDLC);
   assign reload = sync_m ? half - 16'h0001 : dv - 16'h0001;
   assign tick = clk_en && (tcnt_q == 16'h0000);
   // master clock idles high and only runs while there is something to shift
   assign run = nb_q != 4'h0 || !sck_q || tx_valid;
   assign rise = sync_m && (master ? tick && run && !sck_q : clk_en && sclk_in && !sin_q);
   assign fall = sync_m && (master ? tick && run && sck_q : clk_en && !sclk_in && sin_q);
   assign tx_ev = sync_m ? fall : tick;
   assign stuff = hdlc_m && (hst_q == H_DATA) && (ones_q == STUFF_ONES);
   assign rlast = 4'h8 + {3'h0, ~seven} + {3'h0, ninth};
   assign pw = (dv >> IRDA_SHIFT) * IRDA_NUM;
   assign tx_line = (hdlc_m && irda) ? (!line_q && tcnt_q > dv - pw) : line_q;
   assign sclk_out = hdlc_m ? (tcnt_q < half) : sck_q;
   assign sclk_drv = (sync_m && master) || hdlc_m;

   always_comb begin
      fr = '1;
      nb = 4'h8;
      if (!sync_m && !hdlc_m) begin
         fr[8:0] = {tx_data[7:0], 1'b0};
         if (seven) begin
            fr[8:0] = {1'b1, tx_data[6:0], 1'b0};
         end
         if (ninth) begin
            fr[seven ? 8 : 9] = tx_data[8];
         end
         nb = rlast + 4'h1;
      end else begin
         fr[7:0] = tx_data[7:0];
      end
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         tcnt_q <= '0;
         sck_q <= 1'b1;
         sin_q <= 1'b1;
      end else if (clk_en) begin
         tcnt_q <= (tcnt_q == 16'h0000) ? reload : tcnt_q - 16'h0001;
         sin_q <= sclk_in;
         if (master && (rise || fall)) begin
            sck_q <= !sck_q;
         end
      end
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         line_q <= 1'b1;
         tsr_q <= '1;
         nb_q <= '0;
         ones_q <= '0;
         hst_q <= H_IDLE;
         tx_take <= 1'b0;
      end else if (clk_en) begin
         tx_take <= 1'b0;
         if (tx_ev) begin
            if (stuff) begin
               line_q <= 1'b0;
               ones_q <= '0;
            end else if (nb_q != 4'h0) begin
               line_q <= tsr_q[0];
               tsr_q <= {1'b1, tsr_q[10:1]};
               nb_q <= nb_q - 4'h1;
               ones_q <= (tsr_q[0] && hst_q == H_DATA) ? ones_q + 3'h1 : 3'h0;
            end else if (hdlc_m) begin
               case (hst_q)
                  H_OPEN, H_DATA: begin
                     nb_q <= 4'h7;
                     if (tx_valid) begin
                        line_q <= tx_data[0];
                        tsr_q <= {4'hF, tx_data[7:1]};
                        ones_q <= tx_data[0] ? ones_q + 3'h1 : 3'h0;
                        tx_take <= 1'b1;
                        hst_q <= H_DATA;
                     end else begin
                        line_q <= HDLC_FLAG[0];
                        tsr_q <= {4'hF, HDLC_FLAG[7:1]};
                        ones_q <= '0;
                        hst_q <= H_CLOSE;
                     end
                  end
                  H_IDLE: begin
                     if (tx_valid) begin
                        line_q <= HDLC_FLAG[0];
                        tsr_q <= {4'hF, HDLC_FLAG[7:1]};
                        nb_q <= 4'h7;
                        ones_q <= '0;
                        hst_q <= H_OPEN;
                     end
                  end
                  default: begin
                     line_q <= 1'b1;
                     hst_q <= H_IDLE;
                  end
               endcase
            end else if (tx_valid) begin
               line_q <= fr[0];
               tsr_q <= {1'b1, fr[10:1]};
               nb_q <= nb - 4'h1;
               tx_take <= 1'b1;
            end
         end
      end
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         rbusy_q <= 1'b0;
         rcnt_q <= '0;
         rbit_q <= '0;
         rsr_q <= '0;
         rx_valid <= 1'b0;
         rx_data <= '0;
         rx_err <= 1'b0;
      end else if (clk_en) begin
         rx_valid <= 1'b0;
         if (sync_m) begin
            if (rise) begin
               rsr_q[rbit_q[2:0]] <= rx_line;
               rbit_q <= {1'b0, rbit_q[2:0] + 3'h1};
               if (rbit_q[2:0] == 3'h7) begin
                  rx_valid <= 1'b1;
                  rx_data <= {1'b0, rx_line, rsr_q[6:0]};
                  rx_err <= 1'b0;
               end
            end
         end else if (!hdlc_m) begin
            if (!rbusy_q) begin
               rbit_q <= '0;
               rsr_q <= '0;
               if (!rx_line) begin
                  rbusy_q <= 1'b1;
                  rcnt_q <= half;
               end
            end else if (rcnt_q != 16'h0000) begin
               rcnt_q <= rcnt_q - 16'h0001;
            end else begin
               rcnt_q <= dv - 16'h0001;
               rbit_q <= rbit_q + 4'h1;
               // high at mid start bit was a glitch, not a start
               if (rbit_q == 4'h0 && rx_line) begin
                  rbusy_q <= 1'b0;
               end else if (rbit_q == rlast) begin
                  rbusy_q <= 1'b0;
                  rx_valid <= 1'b1;
                  rx_err <= !rx_line;
                  rx_data <= {rsr_q[8] & ninth, rsr_q[7] & !seven, rsr_q[6:0]};
               end else if (rbit_q != 4'h0 && rbit_q <= (seven ? 4'h7 : 4'h8)) begin
                  rsr_q[rbit_q - 4'h1] <= rx_line;
               end else if (rbit_q != 4'h0) begin
                  rsr_q[8] <= rx_line;
               end
            end
         end
      end
   end

   default clocking @(posedge mclk); endclocking
   default disable iff (!arst_n);
   a_bit_time_min: assert property (tick && !sync_m |=> !tick [*7])
      else $error("bit time shorter than eight clocks");
   a_start_low: assert property (tx_ev && !sync_m && !hdlc_m && nb_q == 4'h0 && tx_valid
      |=> !line_q && nb_q == rlast)
      else $error("async frame did not open with a low start bit");
   a_stuff_limit: assert property (hdlc_m && hst_q == H_DATA |-> ones_q <= STUFF_ONES)
      else $error("six ones sent inside a framed data run");
endmodule // ssu_chan

// ---- verification/ssu_peer.sv ----
// Purpose: far-side serial peer: async sender and receiver, sync clock source
// Assumes: line_in is the routed transmit pin of the channel under test
// Notes: the data line turns to the inverse level once a sync frame ends
`timescale 1ns/1ps
module ssu_peer (
   input wire logic mclk,
   input wire logic line_in,
   output logic tx_out,
   output logic ck_out
);
   initial begin
      tx_out = 1'h1;
      ck_out = 1'h1;
   end

   // samples on the falling edge, clear of the pin flop's launch edge
   task automatic rx_async(input int div, input int n, output logic [8:0] got,
      output logic stp, output bit ok);
      int t;
      got = 9'h000;
      ok = 1'h0;
      stp = 1'h0;
      for (t = 0; t < 8000 && line_in !== 1'h0; t++) @(negedge mclk);
      if (line_in !== 1'h0) return;
      repeat (div / 2) @(negedge mclk);
      ok = (line_in === 1'h0);
      for (t = 0; t < n; t++) begin
         repeat (div) @(negedge mclk);
         got[t] = line_in;
      end
      repeat (div) @(negedge mclk);
      stp = line_in;
   endtask

   task automatic tx_async(input int div, input int n, input logic [8:0] d, input logic stp);
      tx_out = 1'h0;
      repeat (div) @(negedge mclk);
      for (int i = 0; i < n; i++) begin
         tx_out = d[i];
         repeat (div) @(negedge mclk);
      end
      tx_out = stp;
      repeat (div) @(negedge mclk);
      tx_out = 1'h1;
      repeat (div) @(negedge mclk);
   endtask

   // peer clocks the frame at 160 ns; clock stands high between frames
   task automatic tx_sync(input logic [7:0] d);
      #3;
      for (int i = 0; i < 8; i++) begin
         ck_out = 1'h0;
         tx_out = d[i];
         #80 ck_out = 1'h1;
         #80;
      end
      tx_out = ~d[7];
   endtask
endmodule // ssu_peer

// ---- verification/ssu_top_tb.sv ----
// Purpose: self-checking bench of the six-channel serial unit
// Assumes: reset stretch shortened to 4 cycles
// Notes: unused pins carry a changing pattern, never a settled level
`timescale 1ns/1ps
module ssu_top_tb;
   import ssu_pkg::*;
   logic mclk = 1'h0;
   logic arst_n, clk_en, boot_select_pins, prog_status, download_done, status_gpo;
   logic status_out, boot_level, prog_mode, reset_out_n, peer_tx, peer_ck, mon_line;
   ssu_mode_t cfg_mode [NCH];
   logic [NCH-1:0][15:0] cfg_div;
   logic [NCH-1:0] cfg_seven, cfg_ninth, cfg_master, cfg_irda, tx_valid, tx_take;
   logic [NCH-1:0] rx_valid, rx_err;
   logic [NCH-1:0][1:0] cfg_tx_sel, cfg_rx_sel;
   logic [NCH-1:0][2:0] cfg_clk_sel;
   logic [NCH-1:0][8:0] tx_data, rx_data;
   logic [NPIN-1:0] pin_in, pin_out, pin_oe_n;
   logic [31:0] seed = 32'h5A4D;
   logic [31:0] noise = 32'h5A4D;
   int mon = 14;
   int rxi = 15;
   int cki = 31;
   int miscompares = 0;
   int checks = 0;
   int q[$];

   always #4 mclk = ~mclk;
   assign mon_line = pin_out[mon];
   always_comb begin
      pin_in = noise;
      pin_in[rxi] = peer_tx;
      pin_in[cki] = peer_ck;
   end

   ssu_top #(.RST_CYC(4)) DUT (.mclk, .arst_n, .clk_en, .boot_select_pins, .prog_status,
      .download_done, .status_gpo, .status_out, .boot_level, .prog_mode, .reset_out_n,
      .cfg_mode, .cfg_div, .cfg_seven, .cfg_ninth, .cfg_master, .cfg_irda, .cfg_tx_sel,
      .cfg_rx_sel, .cfg_clk_sel, .tx_valid, .tx_data, .tx_take, .rx_valid, .rx_data,
      .rx_err, .pin_in, .pin_out, .pin_oe_n);
   ssu_peer peer (.mclk, .line_in(mon_line), .tx_out(peer_tx), .ck_out(peer_ck));

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   always @(negedge mclk) noise <= lfsr(noise);

   // expected word: data field, ninth bit placed at pos
   function automatic int ex(input logic [8:0] d, input bit s, input bit nb, input int pos);
      return int'(d & (s ? 9'h07F : 9'h0FF)) | (nb ? int'(d[8]) << pos : 0);
   endfunction

   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic final_report();
      if (miscompares == 0 && checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   task automatic tout(input bit late);
      if (late) begin
         miscompares++;
         final_report();
      end
   endtask

   task automatic tx_word(input int ch, input logic [8:0] d);
      int t;
      @(negedge mclk);
      tx_valid[ch] = 1'h1;
      tx_data[ch] = d;
      for (t = 0; t < 4000 && tx_take[ch] !== 1'h1; t++) @(negedge mclk);
      tout(t == 4000);
      tx_valid[ch] = 1'h0;
   endtask

   task automatic tx_chk(input int ch, input int div, input bit s, input bit nb);
      logic [8:0] d, got;
      logic stp;
      bit ok;
      seed = lfsr(seed);
      d = seed[8:0];
      q.push_back(ex(d, s, nb, s ? 7 : 8));
      fork
         tx_word(ch, d);
         peer.rx_async(div, (s ? 7 : 8) + nb, got, stp, ok);
      join
      tout(!ok);
      check("tx_bits", got, q.pop_front());
      check("tx_stop", stp, 1'h1);
   endtask

   task automatic rx_chk(input int ch, input int div, input bit s, input bit nb,
      input logic stp, input bit snc);
      logic [8:0] d;
      int t;
      seed = lfsr(seed);
      d = seed[8:0];
      q.push_back(ex(d, snc ? 1'h0 : s, snc ? 1'h0 : nb, 8));
      fork
         if (snc) peer.tx_sync(d[7:0]);
         else peer.tx_async(div, (s ? 7 : 8) + nb, 9'(ex(d, s, nb, s ? 7 : 8)), stp);
         for (t = 0; t < 4000 && rx_valid[ch] !== 1'h1; t++) @(negedge mclk);
      join
      tout(t == 4000);
      check("rx_data", rx_data[ch] & (snc ? 9'h0FF : 9'h1FF), q.pop_front());
      if (!snc) check("rx_err", rx_err[ch], !stp);
   endtask

   initial begin
      bit hit;
      logic [8:0] got, hd;
      logic stp;
      bit ok;
      {arst_n, download_done, status_gpo} = 3'h0;
      {clk_en, boot_select_pins, prog_status} = 3'h7;
      for (int c = 0; c < NCH; c++) begin
         cfg_mode[c] = SSU_ASYNC;
         cfg_div[c] = 16'h0008;
         cfg_tx_sel[c] = 2'h3;
         cfg_rx_sel[c] = 2'h3;
         cfg_clk_sel[c] = 3'h7;
      end
      {cfg_seven, cfg_ninth, cfg_master, cfg_irda, tx_valid, tx_data} = '0;
      repeat (8) @(negedge mclk);
      check("reset_out_n", reset_out_n, 1'h0);
      check("pin_oe_n", pin_oe_n, 32'hFFFFFFFF);
      arst_n = 1'h1;
      repeat (4) @(negedge mclk);
      check("reset_out_n", reset_out_n, 1'h0);
      @(negedge mclk);
      check("reset_out_n", reset_out_n, 1'h1);
      check("prog_mode", prog_mode, 1'h1);
      check("status_out", status_out, 1'h1);
      // boot port ignores the user's div and pin choices
      tx_chk(0, 16, 1'h0, 1'h0);
      rx_chk(0, 16, 1'h0, 1'h0, 1'h1, 1'h0);
      download_done = 1'h1;
      @(negedge mclk);
      download_done = 1'h0;
      repeat (3) @(negedge mclk);
      check("status_out", status_out, 1'h0);
      status_gpo = 1'h1;
      repeat (3) @(negedge mclk);
      check("status_out", status_out, 1'h1);
      arst_n = 1'h0;
      boot_select_pins = 1'h0;
      repeat (2) @(negedge mclk);
      check("reset_out_n", reset_out_n, 1'h0);
      arst_n = 1'h1;
      repeat (6) @(negedge mclk);
      check("prog_mode", prog_mode, 1'h0);
      boot_select_pins = 1'h1;
      repeat (4) @(negedge mclk);
      check("boot_level", boot_level, 1'h1);
      check("prog_mode", prog_mode, 1'h0);
      cfg_tx_sel[0] = 2'h0;
      cfg_rx_sel[0] = 2'h0;
      for (int i = 0; i < 4; i++) begin
         cfg_div[0] = (i == 0) ? 16'h0003 : 16'h0008; // below the floor acts as 8
         cfg_seven[0] = i[0];
         cfg_ninth[0] = i[1];
         tx_chk(0, 8, i[0], i[1]);
         rx_chk(0, 8, i[0], i[1], 1'h1, 1'h0);
      end
      check("tx_oe", pin_oe_n[14], 1'h0);
      rx_chk(0, 8, 1'h1, 1'h1, 1'h0, 1'h0);
      cfg_tx_sel[0] = 2'h1;
      cfg_rx_sel[0] = 2'h3;
      mon = 15;
      tx_chk(0, 8, 1'h1, 1'h1);
      check("alt_oe", pin_oe_n[15:14], 2'h1);
      // unassigned framed channel must never accept data
      cfg_rx_sel[4] = 2'h0;
      tx_valid[4] = 1'h1;
      hit = 1'h0;
      repeat (200) begin
         @(negedge mclk);
         hit = hit | tx_take[4];
      end
      check("unset_take", hit, 1'h0);
      tx_valid[4] = 1'h0;
      // peer onto channel B's pins first, so no stale noise edge reaches the shifter
      rxi = 13;
      cki = 0;
      repeat (4) @(negedge mclk);
      cfg_mode[1] = SSU_SYNC;
      cfg_clk_sel[1] = 3'h0;
      cfg_rx_sel[1] = 2'h0;
      repeat (4) @(negedge mclk);
      rx_chk(1, 0, 1'h0, 1'h0, 1'h1, 1'h1);
      cfg_master[1] = 1'h1;
      repeat (3) @(negedge mclk);
      check("sclk_oe", pin_oe_n[0], 1'h0);
      check("sclk_idle", pin_out[0], 1'h1);
      // framed channel F: opening flag, then the first data bit
      cfg_mode[5] = SSU_HDLC;
      cfg_tx_sel[5] = 2'h0;
      cfg_rx_sel[5] = 2'h0;
      mon = 18;
      repeat (3) @(negedge mclk);
      seed = lfsr(seed);
      hd = seed[8:0];
      q.push_back(int'(hd[0]));
      fork
         tx_word(5, hd);
         peer.rx_async(8, 7, got, stp, ok);
      join
      tout(!ok);
      check("flag_bits", got, 9'h03F);
      check("first_bit", stp, q.pop_front());
      check("f_oe", pin_oe_n[18:16], 3'h2);
      final_report();
   end
endmodule // ssu_top_tb
